/* scan_if_map.svh */
// Register offsets, field positions and reset values of the scan interface control block
`ifndef SCAN_IF_MAP_SVH
`define SCAN_IF_MAP_SVH
`define DEBUG_VIEW_OFS      4'h0
`define START_VECTOR_OFS    4'h4
`define CONTROL_ONE_OFS     4'h8
`define STATUS_OFS          4'hC
`define DEBUG_DAC_MODE      16'h0003
`define CTL_ENABLE_BIT      0
`define CTL_TEST_BIT        1
`define CTL_FLAG0_BIT       2
`define CTL_FLAG6_BIT       8
`define CTL_IE_LSB          9
`define CONTROL_ONE_RESET   16'h0000
`define START_VECTOR_RESET  16'h0000
`define DEBUG_MODE_RESET    16'h0000
`endif

/* scan_if_pkg.sv */
// Types shared by the scan interface control block
package scan_if_pkg;
  typedef enum logic [1:0]
  {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_t;
  typedef logic [15:0] word_t;
endpackage : scan_if_pkg

/* flag_events_if.sv */
// Interface carrying flag set events between the control block and its flag file
`timescale 1ns/1ps
interface flag_events_if;
  logic [6:0] set_ev;     // Hardware set pulses
  logic [6:0] clr_mask;   // Software write of zero
  logic       clr_valid;  // Write strobe
  logic [6:0] flags;      // Current flags
  modport ctrl (output set_ev, output clr_mask, output clr_valid, input flags);
  modport file (input set_ev, input clr_mask, input clr_valid, output flags);
endinterface : flag_events_if

/* irq_flag_file.sv */
// Sticky interrupt flags, set wins over clear
`timescale 1ns/1ps
module irq_flag_file
(
  input  wire logic   ref_clk_i,
  input  wire logic   rst_i,
  flag_events_if.file ev
);
  // One sticky bit per flag
  genvar g;
  generate
    for (g = 0; g < 7; g++)
    begin : g_flag
      logic flag_reg;   // Pending bit
      always_ff @(posedge ref_clk_i or posedge rst_i)
      begin
        if (rst_i)
          flag_reg <= 1'b0;
        else if (ev.set_ev[g])
          flag_reg <= 1'b1;          // Set wins
        else if (ev.clr_valid && ev.clr_mask[g])
          flag_reg <= 1'b0;          // Software clears
      end
      assign ev.flags[g] = flag_reg;
      flag_sticky_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ev.set_ev[g] |=> flag_reg) else $error("flag not set");
    end
  endgenerate
endmodule : irq_flag_file

/* scan_if_flag_vector_ctrl.sv */
// Scan interface debug view, start vector and control register with flags
// Summary of operation
// - Debug mode 03h reads selected DAC register
// - Start vector gives first processing state address
// - Control bits 15..9 enable flag requests
// - Flag 6 sets on top-bit state entry
// - Flag 0 sets from selected channel conditions
// - Test request inserts one cycle, self-clears
// - Control bit 0 enables scan interface
//
// The Avalon-MM slave port and the register offsets were decided locally.
`include "scan_if_map.svh"
`timescale 1ns/1ps
module scan_if_flag_vector_ctrl
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  avs_address,       // Byte address
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [15:0] dac_selected_i,    // Selected DAC register value
  input  wire logic [2:0]  dac_index_i,       // Active DAC register number
  input  wire logic [7:0]  state_outputs_i,   // Processing state outputs
  input  wire logic        state_step_i,      // New state entered pulse
  input  wire logic        channel_cond_i,    // Selected channel condition
  input  wire logic [5:1]  other_flag_ev_i,   // Set pulses of flags 1..5
  input  wire logic        test_cycle_done_i, // End of inserted test cycle
  output logic             scan_enable_o,
  output logic             test_request_o,
  output logic      [15:0] start_vector_o,
  output logic             irq_o
);
  // Register state
  logic [15:0] debug_mode_reg;      // Last value written to debug view
  logic [15:0] start_vector_reg;    // First state address
  logic [6:0]  ie_reg;              // Enable bits 15..9
  logic        enable_reg;          // Module enable
  logic        test_reg;            // Test cycle request
  logic        chan_q1, chan_q2, chan_q3;   // Pin synchroniser
  logic        cond_edge;
  scan_if_pkg::bus_state_t bus_state;
  logic [15:0] wdata;
  logic        wr_ctl, rd_hit;
  flag_events_if fe ();

  irq_flag_file u_flags (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ev(fe));

  // Write data in low half; upper bits ignored
  assign wdata = avs_writedata[15:0];
  // Writes land at the acknowledge edge, where the master sees waitrequest low
  assign wr_ctl = avs_write && bus_state == scan_if_pkg::BUS_ACK
                  && avs_address == `CONTROL_ONE_OFS && avs_byteenable[0];

  // Channel condition comes from outside the clock: three stages
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      chan_q1 <= 1'b0;
      chan_q2 <= 1'b0;
      chan_q3 <= 1'b0;
    end
    else
    begin
      chan_q1 <= channel_cond_i;
      chan_q2 <= chan_q1;
      chan_q3 <= chan_q2;
    end
  end
  // Rising edge: stage two high while stage three still low
  assign cond_edge = chan_q2 && !chan_q3;

  // Flag set events, only while enabled
  assign fe.set_ev[0] = enable_reg && cond_edge;
  assign fe.set_ev[5:1] = enable_reg ? other_flag_ev_i : 5'h00;
  assign fe.set_ev[6] = enable_reg && state_step_i && state_outputs_i[7];
  // Zero written to a flag bit clears it
  assign fe.clr_valid = wr_ctl;
  assign fe.clr_mask = ~{wdata[`CTL_FLAG6_BIT], wdata[7:`CTL_FLAG0_BIT]};

  // Control register fields
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ie_reg     <= 7'h00;
      enable_reg <= 1'b0;
    end
    else if (wr_ctl)
    begin
      ie_reg     <= wdata[15:`CTL_IE_LSB];
      enable_reg <= wdata[`CTL_ENABLE_BIT];
    end
  end

  // Test request: set by software, cleared by end of test cycle
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      test_reg <= 1'b0;
    else if (wr_ctl && wdata[`CTL_TEST_BIT])
      test_reg <= 1'b1;
    else if (test_cycle_done_i)
      test_reg <= 1'b0;
  end

  // Vector and debug mode registers
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      start_vector_reg <= `START_VECTOR_RESET;
      debug_mode_reg   <= `DEBUG_MODE_RESET;
    end
    else if (avs_write && bus_state == scan_if_pkg::BUS_ACK && avs_byteenable[0])
    begin
      if (avs_address == `START_VECTOR_OFS)
        start_vector_reg <= wdata;
      if (avs_address == `DEBUG_VIEW_OFS)
        debug_mode_reg <= wdata;
    end
  end

  // Read mux
  function automatic logic [31:0] read_mux(input logic [3:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `DEBUG_VIEW_OFS:
        if (debug_mode_reg == `DEBUG_DAC_MODE)
          r = {16'h0000, 1'b0, dac_index_i, 2'b00, dac_selected_i[9:0]};
      `START_VECTOR_OFS:
        r = {16'h0000, start_vector_reg};
      `CONTROL_ONE_OFS:
        r = {16'h0000, ie_reg, fe.flags[6], fe.flags[5:0], test_reg, enable_reg};
      `STATUS_OFS:
        r = {25'h0000000, fe.flags};
      default:
        r = 32'h0000_0000;
    endcase
    return r;
  endfunction : read_mux

  // Bus: one wait cycle then acknowledge
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bus_state       <= scan_if_pkg::BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end
    else
    begin
      case (bus_state)
        scan_if_pkg::BUS_IDLE:
          if (avs_read || avs_write)
          begin
            bus_state       <= scan_if_pkg::BUS_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? read_mux(avs_address) : 32'h0000_0000;
          end
        scan_if_pkg::BUS_ACK:
        begin
          bus_state       <= scan_if_pkg::BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default:
          bus_state <= scan_if_pkg::BUS_IDLE;
      endcase
    end
  end

  // Outputs from flip-flops
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(fe.flags & ie_reg);
  end
  assign scan_enable_o  = enable_reg;
  assign test_request_o = test_reg;
  assign start_vector_o = start_vector_reg;

  // Checks
  irq_gate_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ##1 irq_o == |($past(fe.flags) & $past(ie_reg))) else $error("irq wrong");
  top_bit_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    enable_reg && state_step_i && state_outputs_i[7] |=> fe.flags[6])
    else $error("flag 6 missed");
  test_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    test_cycle_done_i && !wr_ctl |=> !test_reg) else $error("test stuck");
  enable_wr_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wr_ctl |=> enable_reg == $past(wdata[0])) else $error("enable wrong");
  vector_out_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    avs_write && bus_state == scan_if_pkg::BUS_ACK && avs_byteenable[0]
    && avs_address == `START_VECTOR_OFS |=> start_vector_o == $past(wdata))
    else $error("vector wrong");
  flag_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    fe.flags[0] && !wr_ctl |=> fe.flags[0]) else $error("flag0 dropped");
  clear_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wr_ctl && !wdata[8] && !fe.set_ev[6] |=> !fe.flags[6]) else $error("no clear");
  dac_view_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    bus_state == scan_if_pkg::BUS_IDLE && avs_read && avs_address == `DEBUG_VIEW_OFS
    && debug_mode_reg == `DEBUG_DAC_MODE |=> avs_readdata[14:12] == $past(dac_index_i))
    else $error("debug view wrong");
  irq_c: cover property (@(posedge ref_clk_i) irq_o);
  test_c: cover property (@(posedge ref_clk_i) test_reg ##1 !test_reg);
  dbg_c: cover property (@(posedge ref_clk_i) avs_read && debug_mode_reg == `DEBUG_DAC_MODE);
endmodule : scan_if_flag_vector_ctrl

/* tb.sv */
// Self-checking bench for the scan interface flag, vector and control block
`timescale 1ns/1ps
module tb;
  logic        ref_clk_i = 1'b0;           // 200 MHz clock
  logic        rst_i = 1'b1;               // Async reset
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] dac_sel = 16'h0000;         // Selected DAC value
  logic [2:0]  dac_idx = 3'h0;             // Selected DAC number
  logic [7:0]  st_out = 8'h00;             // State outputs
  logic        st_step = 1'b0;
  logic        chan = 1'b0;
  logic [5:1]  oth_ev = 5'h00;
  logic        tdone = 1'b0;
  logic        scan_enable_o, test_request_o, irq_o;
  logic [15:0] start_vector_o;
  int          n_fail = 0;
  int          checks_done = 0;
  int          cyc = 0;                    // Timeout counter
  int          seed = 36701;
  logic [15:0] q, v;                       // Read data, random value
  scan_if_flag_vector_ctrl dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dac_selected_i(dac_sel), .dac_index_i(dac_idx),
    .state_outputs_i(st_out), .state_step_i(st_step), .channel_cond_i(chan),
    .other_flag_ev_i(oth_ev), .test_cycle_done_i(tdone), .scan_enable_o(scan_enable_o),
    .test_request_o(test_request_o), .start_vector_o(start_vector_o), .irq_o(irq_o));
  // Free-running clock
  initial
  begin
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // Hang guard; ceiling well above the roughly one hundred cycles needed
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      end_of_test();
    end
  end
  // Single comparison point
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One Avalon transfer; holds everything until waitrequest is seen low
  task automatic bus(input bit wr, input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {16'h0000, d};
    do @(posedge ref_clk_i); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // Wait for n clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : tick
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  // Main sequence; the expected values below form the bench's model
  initial
  begin
    tick(6);
    rst_i <= 1'b0;
    bus(0, 4'h8, 16'h0000); chk(q, 16'h0000);
    bus(0, 4'h4, 16'h0000); chk(q, 16'h0000);
    $display("reset values done");
    v = $random(seed);
    bus(1, 4'h4, v);
    bus(0, 4'h4, 16'h0000); chk(q, v);
    chk(start_vector_o, v);
    bus(1, 4'h2, 16'hFFFF);
    bus(0, 4'h2, 16'h0000); chk(q, 16'h0000);
    $display("vector done");
    dac_sel <= $random(seed);
    dac_idx <= $random(seed);
    bus(1, 4'h0, 16'h0003);
    bus(0, 4'h0, 16'h0000); chk(q, {1'b0, dac_idx, 2'b00, dac_sel[9:0]});
    $display("debug view done");
    bus(1, 4'h8, 16'hFE01);
    tick(1);
    chk({15'h0000, scan_enable_o}, 16'h0001);
    chk({15'h0000, irq_o}, 16'h0000);
    // A step without the top output bit must leave flag 6 alone
    st_out <= 8'h7F; st_step <= 1'b1; tick(1); st_step <= 1'b0;
    bus(0, 4'hC, 16'h0000); chk(q, 16'h0000);
    st_out <= 8'h80; st_step <= 1'b1; tick(1); st_step <= 1'b0;
    bus(0, 4'hC, 16'h0000); chk(q, 16'h0040);
    chk({15'h0000, irq_o}, 16'h0001);
    for (int i = 1; i <= 5; i++)
    begin
      oth_ev <= 5'h01 << (i - 1); tick(1); oth_ev <= 5'h00;
      bus(0, 4'hC, 16'h0000); chk(q, 16'h0040 | ((16'h0002 << i) - 16'h0002));
    end
    chan <= 1'b1; tick(8);
    bus(0, 4'hC, 16'h0000); chk(q, 16'h007F);
    $display("flag sets done");
    // Ones leave flags alone; clearing all enables must drop the request
    bus(1, 4'h8, 16'h01FD);
    bus(0, 4'h8, 16'h0000); chk(q, 16'h01FD);
    chk({15'h0000, irq_o}, 16'h0000);
    bus(1, 4'h8, 16'hFE01);
    bus(0, 4'hC, 16'h0000); chk(q, 16'h0000);
    chk({15'h0000, irq_o}, 16'h0000);
    $display("flag clears done");
    bus(1, 4'h8, 16'hFE03);
    tick(1);
    chk({15'h0000, test_request_o}, 16'h0001);
    tdone <= 1'b1; tick(1); tdone <= 1'b0; tick(2);
    chk({15'h0000, test_request_o}, 16'h0000);
    bus(0, 4'h8, 16'h0000); chk(q, 16'hFE01);
    $display("test cycle done");
    end_of_test();
  end
endmodule : tb
